// >>> verilog/pwr_seq.sv
// Reset, power-down, start-up sequencing and general status register
//
// Contract
// - Reset low forces defaults, mute, full attenuation
// - Reset ignores control and audio buses
// - Reset or power-down forces safe output states
// - Reset release runs init then ramps volume
// - Init waits for active master clock
// - Init loads default control values
// - Reset release leaves mute synchronously, quietly
// - Power-down low mutes and stops at once
// - Power-down held keeps mute, ignores buses
// - Power-down release leaves mute quietly
// - Reset high 16 periods early gives slow start
// - Other release orders give fast start
// - Inactive master clock delays fast start
// - Status shows volume change in progress
// - Status holds fixed device code
// - Status ok bit needs no errors, all valid
// - Status all-valid bit low if any channel inactive
module pwr_seq #(
    parameter int FAST_CYC = pwr_seq_pkg::FAST_START_CYC,
    parameter int SLOW_CYC = pwr_seq_pkg::SLOW_START_CYC,
    // Arbitrary code of our own, not any real part's
    parameter logic [4:0] DEVICE_ID = 5'h0015
)
(
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic reset_n_i,
    input wire logic power_down_n_i,
    input wire logic master_clock_in_i,
    input wire logic master_select_i,
    input wire logic ctrl_bus_valid_i,
    input wire logic audio_bus_valid_i,
    input wire logic vol_busy_i,
    input wire logic [5:0] chan_valid_req_i,
    input wire logic clock_error_i,
    input wire logic recovery_active_i,
    output logic ctrl_bus_accept_o,
    output logic audio_bus_accept_o,
    output logic [5:0] chan_valid_o,
    output logic pwm_hard_mute_o,
    output logic pwm_out_enable_o,
    output logic master_clock_output_en_o,
    output logic frame_clk_out_o,
    output logic frame_clk_oe_n_o,
    output logic overload_indicator_o,
    output logic pll_enable_o,
    output logic [7:0] volume_target_o,
    output logic vol_ramp_o,
    output logic [8:0] mclk_ratio_o,
    output logic master_mode_o,
    output logic automute_en_o,
    output logic [1:0] deemph_o,
    output logic [7:0] dc_offset_o,
    output logic [7:0] icd_o,
    output logic running_o,
    output logic [7:0] general_status_o
);
    typedef enum logic [3:0] {
        ST_HOLD = 4'b0001,
        ST_WAIT_MCLK = 4'b0010,
        ST_INIT = 4'b0100,
        ST_RUN = 4'b1000
    } seq_state_e;

    seq_state_e state_reg;
    seq_state_e state_next;
    logic [1:0] rst_sync_reg;
    logic [1:0] pdn_sync_reg;
    logic [1:0] mclk_sync_reg;
    logic mclk_prev_reg;
    logic [6:0] mclk_idle_reg;
    logic [4:0] rst_hi_mclk_reg;
    logic slow_reg;
    logic [pwr_seq_pkg::CNT_W-1:0] cnt_reg;
    logic [7:0] vol_reg;
    logic ramp_reg;
    // Pin levels for the slow-start count and the mode strap, kept apart from the hold path
    logic [1:0] rst_pin_sync_reg;
    logic [1:0] pdn_pin_sync_reg;
    logic [1:0] msel_sync_reg;

    // Either pin low puts the device in its hard-mute hold asynchronously
    wire force_hold = reset_i | ~reset_n_i | ~power_down_n_i;
    wire rst_ok = rst_sync_reg[1];
    wire pdn_ok = pdn_sync_reg[1];
    wire mclk_edge = mclk_sync_reg[1] & ~mclk_prev_reg;
    wire mclk_active = (mclk_idle_reg < 7'(pwr_seq_pkg::MCLK_TIMEOUT_CYC));
    wire run = (state_reg == ST_RUN);
    wire [pwr_seq_pkg::CNT_W-1:0] init_len = slow_reg ? pwr_seq_pkg::CNT_W'(SLOW_CYC)
                                                      : pwr_seq_pkg::CNT_W'(FAST_CYC);
    wire init_done = (cnt_reg >= init_len - 1'b1);
    wire [5:0] valid_now = run ? chan_valid_req_i : 6'h00;
    wire all_valid = &valid_now;
    wire rst_pin_high = rst_pin_sync_reg[1];
    wire pdn_pin_low = ~pdn_pin_sync_reg[1];

    // Two-flop shift used by every pin synchroniser
    function automatic logic [1:0] sync_shift(input logic [1:0] stages, input logic pin);
    begin
        return {stages[0], pin};
    end
    endfunction

    // two-stage reset pin sync
    // Release is seen two edges late so no timing starts on a metastable level
    always_ff @(posedge clock_i or posedge force_hold)
    begin
        if (force_hold)
            rst_sync_reg <= 2'b00;
        else
            rst_sync_reg <= sync_shift(rst_sync_reg, 1'b1);
    end

    always_ff @(posedge clock_i or posedge force_hold)
    begin
        if (force_hold)
            pdn_sync_reg <= 2'b00;
        else
            pdn_sync_reg <= sync_shift(pdn_sync_reg, 1'b1);
    end

    // Reset pin level for the slow-start count; only the system reset clears it
    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
            rst_pin_sync_reg <= 2'b00;
        else
            rst_pin_sync_reg <= sync_shift(rst_pin_sync_reg, reset_n_i);
    end

    // Power-down pin level for the slow-start count
    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
            pdn_pin_sync_reg <= 2'b00;
        else
            pdn_pin_sync_reg <= sync_shift(pdn_pin_sync_reg, power_down_n_i);
    end

    // Mode strap synchronised; it is only meant to change under reset
    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
            msel_sync_reg <= 2'b00;
        else
            msel_sync_reg <= sync_shift(msel_sync_reg, master_select_i);
    end

    // Master clock seen through a synchroniser
    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            mclk_sync_reg <= 2'b00;
            mclk_prev_reg <= 1'b0;
        end
        else
        begin
            mclk_sync_reg <= sync_shift(mclk_sync_reg, master_clock_in_i);
            mclk_prev_reg <= mclk_sync_reg[1];
        end
    end

    // Activity by edge timeout; a stopped clock saturates the idle count
    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
            mclk_idle_reg <= 7'h7f;
        else
        begin
            if (mclk_edge)
                mclk_idle_reg <= 7'h00;
            else if (mclk_active)
                mclk_idle_reg <= mclk_idle_reg + 7'h01;
        end
    end

    // count reset-high mclk periods while power-down held
    // Only the reset pin and the system reset clear this, since power-down must not reset it
    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
            rst_hi_mclk_reg <= 5'h00;
        else if (!rst_pin_high)
            rst_hi_mclk_reg <= 5'h00;
        else if (pdn_pin_low && mclk_edge && rst_hi_mclk_reg < 5'(pwr_seq_pkg::SLOW_MCLK_PERIODS))
            rst_hi_mclk_reg <= rst_hi_mclk_reg + 5'h01;
    end

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            ST_HOLD:
                if (rst_ok && pdn_ok)
                    state_next = ST_WAIT_MCLK;
            ST_WAIT_MCLK:
                if (mclk_active)
                    state_next = ST_INIT;
            ST_INIT:
                if (init_done)
                    state_next = ST_RUN;
            ST_RUN:
                state_next = ST_RUN;
        endcase
    end

    always_ff @(posedge clock_i or posedge force_hold)
    begin
        if (force_hold)
            state_reg <= ST_HOLD;
        else
            state_reg <= state_next;
    end

    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
            slow_reg <= 1'b0;
        else if (state_reg == ST_HOLD && rst_ok && pdn_ok)
            slow_reg <= (rst_hi_mclk_reg >= 5'(pwr_seq_pkg::SLOW_MCLK_PERIODS));
        else if (state_reg == ST_WAIT_MCLK && !mclk_active)
            slow_reg <= 1'b0;
    end

    always_ff @(posedge clock_i or posedge force_hold)
    begin
        if (force_hold)
            cnt_reg <= '0;
        else if (state_reg == ST_INIT)
            cnt_reg <= cnt_reg + 1'b1;
        else
            cnt_reg <= '0;
    end

    // quiet synchronous ramp to 0 dB
    always_ff @(posedge clock_i or posedge force_hold)
    begin
        if (force_hold)
        begin
            vol_reg <= pwr_seq_pkg::VOL_FULL_ATTEN;
            ramp_reg <= 1'b0;
        end
        else if (state_reg == ST_INIT && init_done)
        begin
            vol_reg <= pwr_seq_pkg::VOL_0DB;
            ramp_reg <= 1'b1;
        end
        else if (run && ramp_reg && !vol_busy_i)
            ramp_reg <= 1'b0;
    end

    always_ff @(posedge clock_i or posedge force_hold)
    begin
        if (force_hold)
        begin
            mclk_ratio_o <= pwr_seq_pkg::MCLK_RATIO_INIT;
            master_mode_o <= 1'b0;
            automute_en_o <= 1'b1;
            deemph_o <= pwr_seq_pkg::DEEMPH_INIT;
            dc_offset_o <= pwr_seq_pkg::DC_OFFSET_INIT;
            icd_o <= pwr_seq_pkg::ICD_INIT;
        end
        else if (state_reg == ST_WAIT_MCLK)
        begin
            // Strap caught after release, never under reset
            master_mode_o <= msel_sync_reg[1];
            mclk_ratio_o <= pwr_seq_pkg::MCLK_RATIO_INIT;
            automute_en_o <= 1'b1;
            deemph_o <= pwr_seq_pkg::DEEMPH_INIT;
            dc_offset_o <= pwr_seq_pkg::DC_OFFSET_INIT;
            icd_o <= pwr_seq_pkg::ICD_INIT;
        end
    end

    assign ctrl_bus_accept_o = run & ctrl_bus_valid_i;
    assign audio_bus_accept_o = run & audio_bus_valid_i;

    assign chan_valid_o = valid_now;
    assign pwm_hard_mute_o = ~run;
    assign pwm_out_enable_o = run;
    assign master_clock_output_en_o = run & master_mode_o;
    assign frame_clk_out_o = 1'b0;
    // Slave mode and hold leave the frame clocks as inputs; master mode drives them low once the strap is caught
    assign frame_clk_oe_n_o = ~master_mode_o;
    assign overload_indicator_o = ~run;
    assign pll_enable_o = ~force_hold;
    assign volume_target_o = vol_reg;
    assign running_o = run;

    assign vol_ramp_o = ramp_reg | (run & vol_busy_i);

    always_comb
    begin
        general_status_o = 8'h00;
        general_status_o[pwr_seq_pkg::STAT_VOL_BIT] = vol_ramp_o;
        general_status_o[pwr_seq_pkg::STAT_OK_BIT] = all_valid & ~clock_error_i & ~recovery_active_i;
        general_status_o[pwr_seq_pkg::STAT_ALLVALID_BIT] = all_valid;
        general_status_o[pwr_seq_pkg::STAT_ID_LSB +: pwr_seq_pkg::STAT_ID_W] = DEVICE_ID;
    end
endmodule

// >>> verilog/pwr_seq_pkg.sv
// Constants for the reset, power-down and status sequencer
package pwr_seq_pkg;
    localparam int CLK_HZ = 25_000_000;
    // Start-up windows, taken at the longer figure so the least time is met
    localparam int FAST_START_US = 4500;
    localparam int SLOW_START_US = 97500;
    localparam int FAST_START_CYC = (CLK_HZ / 1000) * FAST_START_US / 1000;
    localparam int SLOW_START_CYC = (CLK_HZ / 1000) * SLOW_START_US / 1000;
    // Master clock periods with reset high before power-down release
    localparam int SLOW_MCLK_PERIODS = 16;
    // Master clock reckoned inactive after this many system cycles without an edge
    localparam int MCLK_TIMEOUT_CYC = 64;
    localparam int CNT_W = 22;
    // Status register layout
    localparam int STAT_VOL_BIT = 7;
    localparam int STAT_OK_BIT = 6;
    localparam int STAT_ALLVALID_BIT = 5;
    localparam int STAT_ID_LSB = 0;
    localparam int STAT_ID_W = 5;
    // Initial control values
    localparam logic [7:0] VOL_0DB = 8'h0030;
    localparam logic [7:0] VOL_FULL_ATTEN = 8'h00ff;
    localparam logic [8:0] MCLK_RATIO_INIT = 9'h0100;
    localparam logic [7:0] DC_OFFSET_INIT = 8'h0000;
    localparam logic [7:0] ICD_INIT = 8'h0000;
    localparam logic [1:0] DEEMPH_INIT = 2'h0;
    localparam int NCH = 6;
endpackage

// >>> verification/pwr_seq_sva.sv
// Assertions on the sequencer's pins and status register
module pwr_seq_sva
(
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic reset_n_i,
    input wire logic power_down_n_i,
    input wire logic vol_busy_i,
    input wire logic ctrl_bus_accept_o,
    input wire logic audio_bus_accept_o,
    input wire logic [5:0] chan_valid_o,
    input wire logic pwm_hard_mute_o,
    input wire logic overload_indicator_o,
    input wire logic pll_enable_o,
    input wire logic [7:0] volume_target_o,
    input wire logic [8:0] mclk_ratio_o,
    input wire logic automute_en_o,
    input wire logic running_o,
    input wire logic [7:0] general_status_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (reset_i);
    property p_hold; !reset_n_i || !power_down_n_i |-> !chan_valid_o && pwm_hard_mute_o && overload_indicator_o; endproperty
    property p_atten; !reset_n_i |-> volume_target_o == 8'hff; endproperty
    property p_pll; !power_down_n_i |-> !pll_enable_o; endproperty
    property p_refuse; !running_o |-> !ctrl_bus_accept_o && !audio_bus_accept_o; endproperty
    // Two sync flops plus wait state keep run low
    property p_sync; $rose(power_down_n_i) |-> !running_o [*3]; endproperty
    property p_init; $rose(running_o) |-> volume_target_o == 8'h30 && mclk_ratio_o == 9'h100 && automute_en_o; endproperty
    property p_busy; running_o && vol_busy_i |-> general_status_o[7]; endproperty
    property p_all; general_status_o[5] == (chan_valid_o == 6'h3f); endproperty
    a_hold: assert property (p_hold) else $error("outputs not safe in hold");
    a_atten: assert property (p_atten) else $error("volume not attenuated");
    a_pll: assert property (p_pll) else $error("pll on in power-down");
    a_refuse: assert property (p_refuse) else $error("bus accepted outside run");
    a_sync: assert property (p_sync) else $error("run before sync");
    a_init: assert property (p_init) else $error("bad init values");
    a_busy: assert property (p_busy) else $error("volume bit low while busy");
    a_all: assert property (p_all) else $error("all-valid bit wrong");
    c_run: cover property ($rose(running_o));
    c_pdn: cover property (running_o && !power_down_n_i);
    c_ok: cover property (general_status_o[6]);
endmodule

// >>> verification/pin_ctl_model.sv
// Controller model driving reset, power-down and master clock pins
module pin_ctl_model
(
    input wire logic clock_i,
    output logic reset_n_o,
    output logic power_down_n_o,
    output logic master_clock_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk_on;
    initial
    begin
        reset_n_o = 1'b0;
        power_down_n_o = 1'b0;
        master_clock_o = 1'b0;
        mclk_on = 1'b0;
    end
    // Clock stands low when off, so inactivity is real
    always @(posedge clock_i)
        master_clock_o <= mclk_on ? ~master_clock_o : 1'b0;
    // mute pin lies outside this block
    task automatic pin_low(input bit both, input bit clk_on);
        @(posedge clock_i);
        mclk_on <= clk_on;
        power_down_n_o <= 1'b0;
        if (both)
            reset_n_o <= 1'b0;
    endtask
    task automatic release_pins(input bit slow, input bit clk_on);
        @(posedge clock_i);
        mclk_on <= clk_on;
        if (slow)
        begin
            reset_n_o <= 1'b1;
            repeat (40) @(posedge clock_i);
            power_down_n_o <= 1'b1;
        end
        else
        begin
            repeat (2) @(posedge clock_i);
            power_down_n_o <= 1'b1;
            repeat (2) @(posedge clock_i);
            reset_n_o <= 1'b1;
        end
    endtask
    task automatic clock_on();
        @(posedge clock_i);
        mclk_on <= 1'b1;
    endtask
endmodule

// >>> verification/pwr_seq_bench.sv
// Bench for the reset, power-down and status sequencer
module pwr_seq_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic msel = 1'b1, cv = 1'b0, av = 1'b0, vbusy = 1'b0, cerr = 1'b0, recov = 1'b0;
    logic [5:0] creq = 6'h00;
    logic rst_n, pd_n, mclk, cacc, aacc, hmute, oen, mcoe, fclk, foe, ovl, pll, ramp, mmode, amute, run;
    logic [5:0] chv;
    logic [1:0] dem;
    logic [7:0] vol, dco, icd, stat;
    logic [8:0] ratio;
    int bad_count = 0;
    int tests_run = 0;
    pin_ctl_model ctl (.clock_i(clock_i), .reset_n_o(rst_n), .power_down_n_o(pd_n), .master_clock_o(mclk));
    pwr_seq #(.FAST_CYC(20), .SLOW_CYC(50), .DEVICE_ID(5'h15)) DUT (.clock_i(clock_i), .reset_i(reset_i),
        .reset_n_i(rst_n), .power_down_n_i(pd_n), .master_clock_in_i(mclk), .master_select_i(msel),
        .ctrl_bus_valid_i(cv), .audio_bus_valid_i(av), .vol_busy_i(vbusy), .chan_valid_req_i(creq),
        .clock_error_i(cerr), .recovery_active_i(recov), .ctrl_bus_accept_o(cacc), .audio_bus_accept_o(aacc),
        .chan_valid_o(chv), .pwm_hard_mute_o(hmute), .pwm_out_enable_o(oen), .master_clock_output_en_o(mcoe),
        .frame_clk_out_o(fclk), .frame_clk_oe_n_o(foe), .overload_indicator_o(ovl), .pll_enable_o(pll),
        .volume_target_o(vol), .vol_ramp_o(ramp), .mclk_ratio_o(ratio), .master_mode_o(mmode),
        .automute_en_o(amute), .deemph_o(dem), .dc_offset_o(dco), .icd_o(icd), .running_o(run),
        .general_status_o(stat));
    initial
    begin
        forever #20 clock_i = ~clock_i;
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    task automatic check_hold();
        @(posedge clock_i);
        cv <= 1'b1;
        av <= 1'b1;
        creq <= 6'h3f;
        tick(2);
        chk(32'({chv, hmute, oen, mcoe, ovl, pll, cacc, aacc, vol, fclk}), 32'h0000_91fe);
    endtask
    task automatic expect_start(input int lo, input int hi);
        int n;
        n = 0;
        while (run !== 1'b1 && n < 200)
        begin
            tick(1);
            n++;
        end
        if (n == 200)
        begin
            chk(32'h0000_0000, 32'h0000_0001);
            tally_and_finish();
        end
        chk(32'(n >= lo && n <= hi), 32'h0000_0001);
    endtask
    task automatic check_run();
        @(posedge clock_i);
        vbusy <= 1'b1;
        tick(2);
        chk(32'({chv, hmute, oen, mcoe, ovl, pll, cacc, aacc, vol, fclk}), 32'h003f_6e60);
        chk(32'(foe), 32'h0000_0000);
        chk(32'({ratio, mmode, amute, dem, dco, icd}), 32'h100c_0000);
        chk(32'({ramp, stat}), 32'h0000_01f5);
        @(posedge clock_i);
        cerr <= 1'b1;
        tick(1);
        chk(32'(stat), 32'h0000_00b5);
        @(posedge clock_i);
        cerr <= 1'b0;
        vbusy <= 1'b0;
        creq <= 6'h3e;
        tick(2);
        chk(32'({ramp, chv, stat}), 32'h0000_3e15);
    endtask
    initial
    begin
        repeat (8) @(posedge clock_i);
        reset_i <= 1'b0;
        check_hold();
        ctl.release_pins(1'b0, 1'b0);
        tick(100);
        chk(32'(run), 32'h0000_0000);
        ctl.clock_on();
        expect_start(20, 35);
        check_run();
        ctl.pin_low(1'b0, 1'b1);
        check_hold();
        ctl.release_pins(1'b1, 1'b1);
        expect_start(50, 65);
        ctl.pin_low(1'b1, 1'b1);
        check_hold();
        @(posedge clock_i);
        msel <= 1'b0;
        ctl.release_pins(1'b0, 1'b1);
        expect_start(20, 35);
        chk(32'({mmode, mcoe, foe}), 32'h0000_0001);
        tally_and_finish();
    end
endmodule
bind pwr_seq pwr_seq_sva sva_i (.clock_i, .reset_i, .reset_n_i, .power_down_n_i, .vol_busy_i, .ctrl_bus_accept_o,
    .audio_bus_accept_o, .chan_valid_o, .pwm_hard_mute_o, .overload_indicator_o, .pll_enable_o, .volume_target_o,
    .mclk_ratio_o, .automute_en_o, .running_o, .general_status_o);
